// ### power_mode_pkg.sv
package power_mode_pkg;
    // ========================================
    // Register map (byte addresses)
    localparam logic [7:0] LSXC_OFS = 8'h00;
    localparam logic [7:0] SCC_OFS = 8'h04;
    localparam logic [7:0] FXC_OFS = 8'h08;
    localparam logic [7:0] FRC_OFS = 8'h0C;
    localparam logic [7:0] STAT_OFS = 8'h10;
    localparam logic [7:0] PORTA_WAKE_ENABLE_REG_OFS = 8'h14;
    // ========================================
    // Field positions
    localparam int OSC_EN_BIT = 0;
    localparam int OSC_STABLE_BIT = 1;
    localparam int LSXC_SPEEDUP_BIT = 2;
    localparam int SCC_LOW_KEEP_BIT = 0;
    localparam int SCC_HIGH_KEEP_BIT = 1;
    localparam int SCC_LOW_SRC_BIT = 2;
    localparam int SCC_FAST_SRC_BIT = 3;
    localparam int SCC_SEL_LSB = 5;
    localparam int SCC_SEL_MSB = 7;
    // ========================================
    // Reset values
    localparam logic [7:0] SCC_RESET = 8'h00;
    localparam logic FXC_EN_RESET = 1'b0;
    localparam logic FRC_EN_RESET = 1'b1;
    localparam logic LSXC_EN_RESET = 1'b0;
    localparam logic LSXC_SP_RESET = 1'b0;
    localparam logic [7:0] PORTA_WAKE_ENABLE_REG_RESET = 8'h00;
    // ========================================
    // Clock select codes and sizes
    localparam logic [2:0] SEL_LOW_CLOCK = 3'h7;
    localparam logic [2:0] SEL_FAST_DIV1 = 3'h0;
    localparam int NUM_IRQ = 8;
    localparam int PORTA_W = 8;
    localparam int START_CNT_W = 20;
    // ========================================
    // Power states
    typedef enum logic [2:0] {
        ST_RUN = 3'b000,
        ST_SLEEP = 3'b001,
        ST_IDLE_LOW = 3'b010,
        ST_IDLE_BOTH = 3'b011,
        ST_IDLE_HIGH = 3'b100
    } power_state_t;
endpackage

// ### power_mode_clock_control.sv
// Overview of operation
// - Slow crystal speed-up bit set gives short, high-power start; clear gives low power.
// - Speed-up bit writes ignored while slow crystal is the system clock.
// - Enabling slow crystal clears its stable flag, then sets it once stable.
// - Slow crystal runs while its enable bit is one, except in sleep and idle-high; enable resets to zero.
// - Unused upper bits of slow crystal control read as zero.
// - Select code 111 moves system clock to the low-speed clock.
// - Low clock is crystal or RC by source bit; switch waits for stability.
// - Select codes 000 to 110 return to fast clock divided by 1 to 64.
// - Halt with both keep bits zero enters sleep, stopping all but watchdog.
// - Halt with only low keep bit set stops fast clock, keeps low.
// - Halt with both keep bits set keeps both clocks, stops execution.
// - Halt with only high keep bit set keeps fast clock, stops low.
// - Low-power states hold memory, registers and I/O port states.
// - Halt sets power-down flag and clears time-out flag.
// - Halt clears the watchdog; it counts on only if enabled.
// - Wake on enabled port A falling edge, interrupt, or watchdog overflow.
// - Power-down flag cleared by power-up or clear-watchdog instruction.
// - Watchdog overflow in low power sets time-out, resets only PC and SP.
// - Per-pin wake enables; pin wake resumes after the halt.
// - Masked or stack-full interrupt wake resumes after halt; else takes interrupt.
// - Interrupt already pending at halt does not wake the device.
// - Fast crystal and fast RC stable flags clear on enable, then set.
//
// Chosen here: the APB slave port and the register addresses.
`timescale 1ns/10ps

module osc_start #(
    parameter int unsigned SLOW_CYC = 8192,
    parameter int unsigned FAST_CYC = 1024
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic run,
    input wire logic fast_start,
    output logic stable
);
    import power_mode_pkg::*;
    logic [START_CNT_W-1:0] cnt_q;
    logic [START_CNT_W-1:0] target;

    assign target = fast_start ? START_CNT_W'(FAST_CYC - 1)
                               : START_CNT_W'(SLOW_CYC - 1);

    // Stopping the oscillator drops the flag, so every restart counts again
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_q <= '0;
            stable <= 1'b0;
        end else if (!run) begin
            cnt_q <= '0;
            stable <= 1'b0;
        end else if (!stable) begin
            if (cnt_q >= target) begin
                stable <= 1'b1;
            end else begin
                cnt_q <= cnt_q + 1'b1;
            end
        end
    end
endmodule

module power_mode_clock_control import power_mode_pkg::*; #(
    parameter int unsigned SLOW_XTAL_LP_CYC = 65536,
    parameter int unsigned SLOW_XTAL_SP_CYC = 8192,
    parameter int unsigned FAST_XTAL_CYC = 4096,
    parameter int unsigned FAST_RC_CYC = 1024
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic halt_exec,
    input wire logic clr_wdt_exec,
    input wire logic wdt_overflow,
    input wire logic wdt_function_en,
    input wire logic [NUM_IRQ-1:0] irq_req,
    input wire logic [NUM_IRQ-1:0] irq_en,
    input wire logic stack_full,
    input wire logic [PORTA_W-1:0] porta_in,
    output logic cpu_stopped,
    output logic io_hold,
    output logic resume_next,
    output logic irq_take,
    output logic pc_sp_reset,
    output logic wdt_clear,
    output logic wdt_count_en,
    output logic [2:0] sysclk_select,
    output logic sysclk_from_low,
    output logic sysclk_run,
    output logic low_src_xtal,
    output logic fast_src_xtal,
    output logic high_speed_clock_run,
    output logic low_speed_clock_run,
    output logic slow_xtal_run,
    output logic slow_xtal_speedup,
    output logic fast_xtal_run,
    output logic fast_rc_run
);
    // ========================================
    // Register state
    logic slow_xtal_enable_q;
    logic slow_xtal_speedup_q;
    logic [2:0] sysclk_select_field_q;
    logic fast_src_q;
    logic low_clock_source_bit_q;
    logic high_osc_keep_bit_q;
    logic low_osc_keep_bit_q;
    logic fast_xtal_en_q;
    logic fast_rc_en_q;
    logic [PORTA_W-1:0] porta_wake_enable_q;
    logic power_down_flag_q;
    logic timeout_flag_q;
    logic [2:0] sel_act_q;
    power_state_t state_q;
    logic [NUM_IRQ-1:0] irq_blocked_q;
    logic slow_xtal_stable_flag;
    logic fast_xtal_stable_flag;
    logic fast_rc_stable_flag;
    logic wr_en;
    logic rd_setup;
    logic mapped;
    logic [7:0] rd_byte;
    logic in_low_power;
    logic low_allowed;
    logic high_allowed;
    logic xtal_selected;
    logic halt_take;
    logic [NUM_IRQ-1:0] irq_wake;
    logic pin_wake;
    logic [PORTA_W-1:0] pa_s1_q;
    logic [PORTA_W-1:0] pa_s2_q;
    logic [PORTA_W-1:0] pa_s3_q;
    logic [PORTA_W-1:0] pa_q;
    logic [PORTA_W-1:0] pa_fall;

    // ========================================
    // APB slave: zero wait states, read data captured in the setup cycle
    assign pready = 1'b1;
    assign wr_en = psel & penable & pwrite & pstrb[0];
    assign rd_setup = psel & ~penable & ~pwrite;
    assign mapped = (paddr == LSXC_OFS) || (paddr == SCC_OFS) ||
                    (paddr == FXC_OFS) || (paddr == FRC_OFS) ||
                    (paddr == STAT_OFS) || (paddr == PORTA_WAKE_ENABLE_REG_OFS);
    assign pslverr = psel & penable & ~mapped;

    always_comb begin
        rd_byte = 8'h00;
        case (paddr)
            LSXC_OFS: begin
                rd_byte[LSXC_SPEEDUP_BIT] = slow_xtal_speedup_q;
                rd_byte[OSC_STABLE_BIT] = slow_xtal_stable_flag;
                rd_byte[OSC_EN_BIT] = slow_xtal_enable_q;
            end
            SCC_OFS: begin
                rd_byte[SCC_SEL_MSB:SCC_SEL_LSB] = sysclk_select_field_q;
                rd_byte[SCC_FAST_SRC_BIT] = fast_src_q;
                rd_byte[SCC_LOW_SRC_BIT] = low_clock_source_bit_q;
                rd_byte[SCC_HIGH_KEEP_BIT] = high_osc_keep_bit_q;
                rd_byte[SCC_LOW_KEEP_BIT] = low_osc_keep_bit_q;
            end
            FXC_OFS: begin
                rd_byte[OSC_STABLE_BIT] = fast_xtal_stable_flag;
                rd_byte[OSC_EN_BIT] = fast_xtal_en_q;
            end
            FRC_OFS: begin
                rd_byte[OSC_STABLE_BIT] = fast_rc_stable_flag;
                rd_byte[OSC_EN_BIT] = fast_rc_en_q;
            end
            STAT_OFS: begin
                rd_byte = {2'b00, sel_act_q == SEL_LOW_CLOCK, state_q,
                           timeout_flag_q, power_down_flag_q};
            end
            PORTA_WAKE_ENABLE_REG_OFS: begin
                rd_byte = porta_wake_enable_q;
            end
            default: begin
                rd_byte = 8'h00;
            end
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
        end else if (rd_setup) begin
            prdata <= {24'h00_0000, rd_byte};
        end
    end

    // ========================================
    // Oscillator control registers
    assign xtal_selected = (sysclk_select_field_q == SEL_LOW_CLOCK) &&
                           low_clock_source_bit_q;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            slow_xtal_enable_q <= LSXC_EN_RESET;
            slow_xtal_speedup_q <= LSXC_SP_RESET;
        end else if (wr_en && paddr == LSXC_OFS) begin
            slow_xtal_enable_q <= pwdata[OSC_EN_BIT];
            if (!xtal_selected) begin
                slow_xtal_speedup_q <= pwdata[LSXC_SPEEDUP_BIT];
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fast_xtal_en_q <= FXC_EN_RESET;
            fast_rc_en_q <= FRC_EN_RESET;
        end else if (wr_en && paddr == FXC_OFS) begin
            fast_xtal_en_q <= pwdata[OSC_EN_BIT];
        end else if (wr_en && paddr == FRC_OFS) begin
            fast_rc_en_q <= pwdata[OSC_EN_BIT];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sysclk_select_field_q <= SCC_RESET[SCC_SEL_MSB:SCC_SEL_LSB];
            fast_src_q <= SCC_RESET[SCC_FAST_SRC_BIT];
            low_clock_source_bit_q <= SCC_RESET[SCC_LOW_SRC_BIT];
            high_osc_keep_bit_q <= SCC_RESET[SCC_HIGH_KEEP_BIT];
            low_osc_keep_bit_q <= SCC_RESET[SCC_LOW_KEEP_BIT];
        end else if (wr_en && paddr == SCC_OFS) begin
            sysclk_select_field_q <= pwdata[SCC_SEL_MSB:SCC_SEL_LSB];
            fast_src_q <= pwdata[SCC_FAST_SRC_BIT];
            low_clock_source_bit_q <= pwdata[SCC_LOW_SRC_BIT];
            high_osc_keep_bit_q <= pwdata[SCC_HIGH_KEEP_BIT];
            low_osc_keep_bit_q <= pwdata[SCC_LOW_KEEP_BIT];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            porta_wake_enable_q <= PORTA_WAKE_ENABLE_REG_RESET;
        end else if (wr_en && paddr == PORTA_WAKE_ENABLE_REG_OFS) begin
            porta_wake_enable_q <= pwdata[PORTA_W-1:0];
        end
    end

    // ========================================
    // Oscillator gating and start-up
    // Low RC is never stopped because the watchdog runs from it
    assign in_low_power = (state_q != ST_RUN);
    assign low_allowed = (state_q != ST_SLEEP) &&
                         (state_q != ST_IDLE_HIGH);
    assign high_allowed = (state_q == ST_RUN) ||
                          (state_q == ST_IDLE_BOTH) ||
                          (state_q == ST_IDLE_HIGH);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            slow_xtal_run <= 1'b0;
            slow_xtal_speedup <= 1'b0;
            fast_xtal_run <= 1'b0;
            fast_rc_run <= 1'b0;
        end else begin
            slow_xtal_run <= slow_xtal_enable_q & low_allowed;
            slow_xtal_speedup <= slow_xtal_speedup_q;
            fast_xtal_run <= fast_xtal_en_q & high_allowed;
            fast_rc_run <= fast_rc_en_q & high_allowed;
        end
    end

    osc_start #(
        .SLOW_CYC(SLOW_XTAL_LP_CYC),
        .FAST_CYC(SLOW_XTAL_SP_CYC)
    ) u_slow_xtal (
        .pclk(pclk),
        .presetn(presetn),
        .run(slow_xtal_run),
        .fast_start(slow_xtal_speedup_q),
        .stable(slow_xtal_stable_flag)
    );

    osc_start #(
        .SLOW_CYC(FAST_XTAL_CYC),
        .FAST_CYC(FAST_XTAL_CYC)
    ) u_fast_xtal (
        .pclk(pclk),
        .presetn(presetn),
        .run(fast_xtal_run),
        .fast_start(1'b0),
        .stable(fast_xtal_stable_flag)
    );

    osc_start #(
        .SLOW_CYC(FAST_RC_CYC),
        .FAST_CYC(FAST_RC_CYC)
    ) u_fast_rc (
        .pclk(pclk),
        .presetn(presetn),
        .run(fast_rc_run),
        .fast_start(1'b0),
        .stable(fast_rc_stable_flag)
    );

    // ========================================
    // System clock selection
    // Going slow waits for the chosen low oscillator; going fast is
    // immediate, so software must poll the fast stable flags itself
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sel_act_q <= SCC_RESET[SCC_SEL_MSB:SCC_SEL_LSB];
        end else if (sysclk_select_field_q == SEL_LOW_CLOCK) begin
            if (!low_clock_source_bit_q || slow_xtal_stable_flag) begin
                sel_act_q <= SEL_LOW_CLOCK;
            end
        end else begin
            sel_act_q <= sysclk_select_field_q;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sysclk_select <= SEL_FAST_DIV1;
            sysclk_from_low <= 1'b0;
            low_src_xtal <= 1'b0;
            fast_src_xtal <= 1'b0;
            sysclk_run <= 1'b0;
            high_speed_clock_run <= 1'b0;
            low_speed_clock_run <= 1'b0;
            cpu_stopped <= 1'b0;
            io_hold <= 1'b0;
            wdt_count_en <= 1'b0;
        end else begin
            sysclk_select <= sel_act_q;
            sysclk_from_low <= (sel_act_q == SEL_LOW_CLOCK);
            low_src_xtal <= low_clock_source_bit_q;
            fast_src_xtal <= fast_src_q;
            sysclk_run <= !in_low_power;
            high_speed_clock_run <= high_allowed;
            low_speed_clock_run <= low_allowed;
            cpu_stopped <= in_low_power;
            io_hold <= in_low_power;
            wdt_count_en <= wdt_function_en;
        end
    end

    // ========================================
    // Port A wake pins: three-stage synchroniser with agreement filter
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pa_s1_q <= '1;
            pa_s2_q <= '1;
            pa_s3_q <= '1;
            pa_q <= '1;
        end else begin
            pa_s1_q <= porta_in;
            pa_s2_q <= pa_s1_q;
            pa_s3_q <= pa_s2_q;
            pa_q <= (pa_s2_q & pa_s3_q) | (pa_q & (pa_s2_q ^ pa_s3_q));
        end
    end

    assign pa_fall = pa_q & ~pa_s2_q & ~pa_s3_q;
    assign pin_wake = |(pa_fall & porta_wake_enable_q);
    assign irq_wake = irq_req & ~irq_blocked_q;

    // ========================================
    // Power state machine
    assign halt_take = halt_exec && (state_q == ST_RUN);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_q <= ST_RUN;
            irq_blocked_q <= '0;
            resume_next <= 1'b0;
            irq_take <= 1'b0;
            pc_sp_reset <= 1'b0;
        end else begin
            resume_next <= 1'b0;
            irq_take <= 1'b0;
            pc_sp_reset <= 1'b0;
            case (state_q)
                ST_RUN: begin
                    if (halt_exec) begin
                        irq_blocked_q <= irq_req;
                        case ({high_osc_keep_bit_q, low_osc_keep_bit_q})
                            2'b00: state_q <= ST_SLEEP;
                            2'b01: state_q <= ST_IDLE_LOW;
                            2'b11: state_q <= ST_IDLE_BOTH;
                            default: state_q <= ST_IDLE_HIGH;
                        endcase
                    end
                end
                ST_SLEEP, ST_IDLE_LOW, ST_IDLE_BOTH, ST_IDLE_HIGH: begin
                    if (wdt_overflow) begin
                        state_q <= ST_RUN;
                        pc_sp_reset <= 1'b1;
                    end else if (|irq_wake) begin
                        state_q <= ST_RUN;
                        if (|(irq_wake & irq_en) && !stack_full) begin
                            irq_take <= 1'b1;
                        end else begin
                            resume_next <= 1'b1;
                        end
                    end else if (pin_wake) begin
                        state_q <= ST_RUN;
                        resume_next <= 1'b1;
                    end
                end
                default: begin
                    state_q <= ST_RUN;
                end
            endcase
        end
    end

    // ========================================
    // Status flags: a set in the same cycle as a clear wins
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            power_down_flag_q <= 1'b0;
            timeout_flag_q <= 1'b0;
            wdt_clear <= 1'b0;
        end else begin
            wdt_clear <= halt_take | clr_wdt_exec;
            if (halt_take) begin
                power_down_flag_q <= 1'b1;
            end else if (clr_wdt_exec) begin
                power_down_flag_q <= 1'b0;
            end
            if (wdt_overflow) begin
                timeout_flag_q <= 1'b1;
            end else if (halt_take) begin
                timeout_flag_q <= 1'b0;
            end
        end
    end
endmodule

// ### pmcc_sva.sv
`timescale 1ns/10ps
module pmcc_sva (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic halt_exec,
    input wire logic wdt_overflow,
    input wire logic stack_full,
    input wire logic cpu_stopped,
    input wire logic io_hold,
    input wire logic resume_next,
    input wire logic irq_take,
    input wire logic pc_sp_reset,
    input wire logic wdt_clear,
    input wire logic [2:0] sysclk_select,
    input wire logic sysclk_from_low,
    input wire logic sysclk_run
);
// ========================================
// Power mode checks
default clocking cb @(posedge pclk); endclocking
default disable iff (!presetn);
a_halt_stops_core: assert property (halt_exec && !cpu_stopped &&
    !$past(halt_exec) |-> ##2 cpu_stopped && io_hold)
    else $error("halt did not stop the core");
a_halt_clears_wdt: assert property (halt_exec && !cpu_stopped &&
    !$past(halt_exec) |-> ##1 wdt_clear)
    else $error("halt did not clear the watchdog");
a_sleep_no_clock: assert property (cpu_stopped |-> !sysclk_run)
    else $error("system clock runs while stopped");
a_low_code_map: assert property (sysclk_from_low == (sysclk_select == 3'h7))
    else $error("low clock flag disagrees with select");
a_wdt_wake_cause: assert property (pc_sp_reset |->
    $past(wdt_overflow) || $past(wdt_overflow, 2))
    else $error("pc reset without watchdog overflow");
a_take_needs_room: assert property (irq_take |-> !$past(stack_full))
    else $error("interrupt taken with full stack");
a_wake_one_kind: assert property ($onehot0({resume_next, irq_take, pc_sp_reset}))
    else $error("more than one wake kind at once");
a_wake_resumes: assert property (resume_next || irq_take || pc_sp_reset
    |-> ##1 !cpu_stopped)
    else $error("core still stopped after wake");
a_select_kept: assert property (cpu_stopped && $past(cpu_stopped)
    |-> $stable(sysclk_select))
    else $error("clock select moved while stopped");
endmodule
bind power_mode_clock_control pmcc_sva u_pmcc_sva (.pclk(pclk),
    .presetn(presetn), .halt_exec(halt_exec), .wdt_overflow(wdt_overflow),
    .stack_full(stack_full), .cpu_stopped(cpu_stopped), .io_hold(io_hold),
    .resume_next(resume_next), .irq_take(irq_take),
    .pc_sp_reset(pc_sp_reset), .wdt_clear(wdt_clear),
    .sysclk_select(sysclk_select), .sysclk_from_low(sysclk_from_low),
    .sysclk_run(sysclk_run));

// ### cpu_model.sv
`timescale 1ns/10ps
module cpu_model (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic go_halt,
    input wire logic cpu_stopped,
    output logic halt_exec
);
// ========================================
// Halt issue
// A stopped core fetches nothing, so it cannot issue a second halt
always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        halt_exec <= 1'b0;
    end else begin
        halt_exec <= go_halt && !cpu_stopped && !halt_exec;
    end
end
endmodule

// ### power_mode_clock_control_tb_top.sv
`timescale 1ns/10ps
module power_mode_clock_control_tb_top;
import power_mode_pkg::*;
logic pclk, presetn, psel, penable, pwrite, halt_exec, go_halt, err;
logic clr_wdt_exec, wdt_overflow, wdt_function_en, stack_full, pready;
logic [7:0] paddr, irq_req, irq_en, porta_in;
logic [31:0] pwdata, prdata, rd, r;
logic pslverr, cpu_stopped, io_hold, resume_next, irq_take, pc_sp_reset;
logic sysclk_from_low, sysclk_run, hs_run, ls_run, sx_run, sx_sp;
logic [2:0] sysclk_select, wk, k, b;
logic [1:0] kb, src;
int num_errors, compares, n, i;
integer seed;
// ========================================
// Design and core model
power_mode_clock_control #(.SLOW_XTAL_LP_CYC(16), .SLOW_XTAL_SP_CYC(8),
    .FAST_XTAL_CYC(8), .FAST_RC_CYC(4)) u_power_mode_clock_control (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'hF),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .halt_exec(halt_exec), .clr_wdt_exec(clr_wdt_exec),
    .wdt_overflow(wdt_overflow), .wdt_function_en(wdt_function_en),
    .irq_req(irq_req), .irq_en(irq_en), .stack_full(stack_full),
    .porta_in(porta_in), .cpu_stopped(cpu_stopped), .io_hold(io_hold),
    .resume_next(resume_next), .irq_take(irq_take),
    .pc_sp_reset(pc_sp_reset), .wdt_clear(), .wdt_count_en(),
    .sysclk_select(sysclk_select), .sysclk_from_low(sysclk_from_low),
    .sysclk_run(sysclk_run), .low_src_xtal(), .fast_src_xtal(),
    .high_speed_clock_run(hs_run), .low_speed_clock_run(ls_run),
    .slow_xtal_run(sx_run), .slow_xtal_speedup(sx_sp),
    .fast_xtal_run(), .fast_rc_run());
cpu_model u_cpu_model (.pclk(pclk), .presetn(presetn), .go_halt(go_halt),
    .cpu_stopped(cpu_stopped), .halt_exec(halt_exec));
// ========================================
// Tasks
task chk(input string s, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
        num_errors++;
        $display("unexpected %s exp %h seen %h", s, exp, seen);
    end
endtask
task close_out;
    $display("compares %0d num_errors %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0) begin
        $display("Finished cleanly");
    end else begin
        $display("Finished with errors");
    end
    $finish;
endtask
// No wait count assumed: the slave answers when pready says so
task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int c;
    c = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
        @(posedge pclk);
        c++;
    end while (pready !== 1'b1 && c < 20);
    if (c >= 20) begin
        num_errors++;
        close_out;
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
endtask
task poll(input logic [7:0] a);
    n = 0;
    do begin
        apb(1'b0, a, 32'h0);
        n++;
    end while (rd[1] !== 1'b1 && n < 40);
    if (n >= 40) begin
        num_errors++;
        close_out;
    end
endtask
// Strobes are picked by number: a task argument is copied out only on
// return, so driving one through the argument would never pulse the pin
task pulse(input int w);
    @(posedge pclk);
    if (w == 0) go_halt <= 1'b1;
    if (w == 1) wdt_overflow <= 1'b1;
    if (w == 2) clr_wdt_exec <= 1'b1;
    @(posedge pclk);
    {go_halt, wdt_overflow, clr_wdt_exec} <= 3'h0;
    repeat (4) @(negedge pclk);
endtask
task wait_wake;
    wk = 3'h0;
    n = 0;
    while (wk === 3'h0 && n < 40) begin
        @(negedge pclk);
        wk = {pc_sp_reset, irq_take, resume_next};
        n++;
    end
    if (wk === 3'h0) begin
        num_errors++;
        close_out;
    end
endtask
function logic [2:0] st_of(input logic [1:0] keep);
    return (keep == 2'h0) ? 3'h1 : (keep == 2'h1) ? 3'h2 :
        (keep == 2'h3) ? 3'h3 : 3'h4;
endfunction
// ========================================
// Stimulus
initial begin
    pclk = 0;
    forever #2 pclk = ~pclk;
end
initial begin
    #300000;
    num_errors++;
    close_out;
end
initial begin
    {presetn, psel, penable, pwrite, go_halt, clr_wdt_exec} = 6'h0;
    {wdt_overflow, wdt_function_en, stack_full} = 3'h0;
    {paddr, irq_req, irq_en, pwdata} = 56'h0;
    porta_in = 8'hFF;
    seed = 32'h8EE69AAE;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, LSXC_OFS, 32'h0);
    chk("slow_ctrl_reset", rd, 32'h0);
    poll(FRC_OFS);
    chk("fast_rc_ready", rd, 32'h3);
    apb(1'b1, LSXC_OFS, 32'hFF);
    apb(1'b0, LSXC_OFS, 32'h0);
    chk("slow_ctrl_fresh", rd, 32'h5);
    chk("slow_run", {sx_run, sx_sp}, 2'h3);
    poll(LSXC_OFS);
    chk("slow_ready", rd, 32'h7);
    apb(1'b1, PORTA_WAKE_ENABLE_REG_OFS, 32'hFF);
    apb(1'b1, SCC_OFS, 32'hE4);
    repeat (4) @(negedge pclk);
    chk("to_slow", {sysclk_from_low, sysclk_select}, 4'hF);
    apb(1'b1, LSXC_OFS, 32'h1);
    apb(1'b0, LSXC_OFS, 32'h0);
    chk("speedup_locked", rd, 32'h7);
    apb(1'b0, 8'h40, 32'h0);
    chk("unmapped", {err, rd[30:0]}, 32'h80000000);
    irq_req <= 8'h01;
    pulse(0);
    repeat (8) @(negedge pclk);
    chk("pending_no_wake", cpu_stopped, 1'b1);
    pulse(1);
    chk("wdt_wake", cpu_stopped, 1'b0);
    apb(1'b0, STAT_OFS, 32'h0);
    chk("wdt_timeout", rd[1:0], 2'h3);
    irq_req <= 8'h00;
    for (i = 0; i < 12; i++) begin
        r = $random(seed);
        k = (r[2:0] == 3'h7) ? 3'h0 : r[2:0];
        kb = r[4:3];
        src = (r[6:5] == 2'h3) ? 2'h1 : r[6:5];
        b = r[10:8];
        irq_en <= r[23:16];
        stack_full <= r[11];
        wdt_function_en <= r[12];
        apb(1'b1, SCC_OFS, {24'h0, k, 3'h1, kb});
        repeat (4) @(negedge pclk);
        chk("fast_code", {sysclk_from_low, sysclk_select}, {1'b0, k});
        pulse(0);
        chk("stopped", {cpu_stopped, io_hold}, 2'h3);
        chk("clocks_kept", {hs_run, ls_run}, kb);
        apb(1'b0, STAT_OFS, 32'h0);
        chk("halt_status", rd[4:0], {st_of(kb), 2'h1});
        if (src == 2'h0) wdt_overflow <= 1'b1;
        if (src == 2'h1) irq_req[b] <= 1'b1;
        if (src == 2'h2) porta_in[b] <= 1'b0;
        @(posedge pclk);
        wdt_overflow <= 1'b0;
        wait_wake;
        chk("wake_kind", wk, (src == 2'h0) ? 3'h4 :
            (src == 2'h1 && irq_en[b] && !stack_full) ? 3'h2 : 3'h1);
        irq_req <= 8'h00;
        porta_in <= 8'hFF;
        repeat (3) @(negedge pclk);
        chk("select_kept", sysclk_select, k);
        apb(1'b0, STAT_OFS, 32'h0);
        chk("wake_flags", rd[1:0], {src == 2'h0, 1'b1});
        pulse(2);
        apb(1'b0, STAT_OFS, 32'h0);
        chk("pd_cleared", rd[0], 1'b0);
    end
    close_out;
end
endmodule
